/* monitor_pin_cfg.svh */
// Offsets, field positions, reset values and timing counts of the monitor pin block
`ifndef MONITOR_PIN_CFG_SVH
`define MONITOR_PIN_CFG_SVH

// Register indexes; byte address is four times the index
`define IDX_CFG       8'h40
`define IDX_RST_CTL   8'h44
`define IDX_CI_CLR    8'h46
`define IDX_IRQ_STAT  8'h50
`define IDX_IRQ_MASK  8'h51
`define IDX_PIN_STAT  8'h52

// Field positions
`define CFG_INT_EN    1
`define CFG_RST_GO    4
`define CFG_CI_GO     6
`define RSTCTL_EN     7
`define CICLR_GO      7
`define EV_INTRUSION  0
`define EV_CI_DONE    1
`define EV_RST_DONE   2
`define EV_BUS_START  3

// Reset values
`define RST_CFG       8'h00
`define RST_RST_CTL   8'h00
`define RST_CI_CLR    8'h00
`define RST_IRQ_STAT  4'h0
`define RST_IRQ_MASK  4'h0

// Timing: pulse width in ms, clock rate in kHz, pulse width and reset guard in cycles
`define PULSE_MS      20
`define CLK_KHZ       200000
`define PULSE_CYCLES  (`PULSE_MS * `CLK_KHZ)
`define GUARD_CYCLES  3

`endif

/* monitor_pin_pkg.sv */
// Types shared by the monitor pin block
`default_nettype none
package monitor_pin_pkg;
  typedef enum logic {PS_IDLE, PS_DRIVE} pulse_state_t;
  typedef enum logic [2:0] {SEL_CFG, SEL_RST_CTL, SEL_CI_CLR, SEL_STAT, SEL_MASK, SEL_PIN,
                            SEL_NONE} reg_sel_t;
endpackage
`default_nettype wire

/* pulse_if.sv */
// Handshake between the control logic and one pulse timer
`timescale 1ns/100ps
`default_nettype none
interface pulse_if;
  logic start;   // One-cycle request to begin a pulse
  logic abort;   // Stop the pulse at once
  logic busy;    // Pin driven low
  logic done;    // One-cycle pulse at expiry
  modport timer (input start, input abort, output busy, output done);
  modport user  (output start, output abort, input busy, input done);
endinterface
`default_nettype wire

/* bit_sync.sv */
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int unsigned    W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk,   // Block clock
  input  wire logic         nrst,  // Async reset, active low
  input  wire logic [W-1:0] d,     // Pin levels, any domain
  output var  logic [W-1:0] q      // Levels on clk
);
  logic [W-1:0] meta_r;

  if (W < 1) $error("bit_sync width must be at least one");

  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* pulse_timer.sv */
// Open-drain pulse timer: holds its drive for a fixed count of cycles
`timescale 1ns/100ps
`default_nettype none
`include "monitor_pin_cfg.svh"
module pulse_timer #(
  parameter int unsigned CYCLES = `PULSE_CYCLES
) (
  input  wire logic clk,  // Block clock
  input  wire logic nrst, // Async reset, active low
  pulse_if.timer    pi    // Start, abort, busy, done
);
  import monitor_pin_pkg::*;
  localparam int unsigned    CW   = $clog2(CYCLES + 1);
  localparam logic [CW-1:0]  LAST = CW'(CYCLES - 1);

  pulse_state_t  st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          busy_r, busy_nxt;
  logic          done_r, done_nxt;

  if (CYCLES < 2) $error("pulse_timer needs at least two cycles");

  assign pi.busy = busy_r;
  assign pi.done = done_r;

  // Next state; expiry releases the drive and reports once
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    case (st_r)
      PS_IDLE: begin
        if (pi.start && !pi.abort) begin
          st_nxt  = PS_DRIVE;
          cnt_nxt = '0;
        end
      end
      PS_DRIVE: begin
        if (pi.abort) begin
          st_nxt = PS_IDLE;
        end else if (cnt_r == LAST) begin
          st_nxt   = PS_IDLE; // RQ12
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: st_nxt = PS_IDLE;
    endcase
    busy_nxt = (st_nxt == PS_DRIVE);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r   <= PS_IDLE;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  start_drive_a: assert property (pi.start && !pi.abort && !busy_r |=> busy_r) // RQ4
    else $error("pulse did not start");
  count_step_a: assert property (busy_r && !pi.abort && cnt_r != LAST
                                 |=> busy_r && cnt_r == $past(cnt_r) + 1'b1) // RQ12
    else $error("pulse ended early or count skipped");
  done_cause_a: assert property (done_r |-> !busy_r && $past(busy_r) && $past(cnt_r) == LAST) // RQ12
    else $error("done without full pulse");
endmodule
`default_nettype wire

/* monitor_pin_ctrl.sv */
// Digital pin control of the hardware monitor with its APB register file
//
// Notes on behaviour
// [RQ1] Address strap pins give the two low programmable serial address bits.
// [RQ2] In NAND tree test the first strap pin becomes the result output.
// [RQ3] High intrusion pin level means a latched chassis intrusion event.
// [RQ4] Setting 40h bit 6 or 46h bit 7 pulls intrusion pin low 20 ms.
// [RQ5] Interrupt output is open drain, gated by config bit 1, off after reset.
// [RQ6] High test select pin enters NAND tree mode; otherwise analog output.
// [RQ7] With 44h bit 7 set, 40h bit 4 drives reset pin low 20 ms.
// [RQ8] External low level on the reset pin is a reset request.
// [RQ9] Serial data pin drives only low; serial clock is input only. Here sda_oe is held low, so the data pin is never driven.
// [RQ10] Low reset pin returns every register to its default.
// [RQ11] The host controls the device only through serial bus transactions. Here registers are reached over APB; serial bus starts are only recorded.
// [RQ12] A counter times each pulse, then releases the pin and clears the bit.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "monitor_pin_cfg.svh"
module monitor_pin_ctrl #(
  parameter int unsigned PULSE_CYCLES = `PULSE_CYCLES
) (
  input  wire logic        clk,                        // 200 MHz block clock
  input  wire logic        nrst,                       // Async reset, active low
  input  wire logic        psel,                       // APB select
  input  wire logic        penable,                    // APB access phase
  input  wire logic        pwrite,                     // APB write
  input  wire logic [11:0] paddr,                      // APB byte address
  input  wire logic [31:0] pwdata,                     // APB write data
  output var  logic [31:0] prdata,                     // APB read data
  output var  logic        pready,                     // APB ready
  output var  logic        pslverr,                    // APB error, unmapped
  input  wire logic        addr_bit0_test_out_i,       // Strap bit 0 pin level
  output var  logic        addr_bit0_test_out_o,       // NAND tree result
  output var  logic        addr_bit0_test_out_oe,      // High in test mode
  input  wire logic        addr_bit1_strap,            // Strap bit 1 pin
  input  wire logic        sda_i,                      // Serial data level
  output var  logic        sda_o,                      // Serial data drive value
  output var  logic        sda_oe,                     // Serial data drive enable
  input  wire logic        scl_i,                      // Serial clock, input only
  input  wire logic        intrusion_detect_pin_i,     // Intrusion latch level
  output var  logic        intrusion_detect_pin_o,     // Drive value, low
  output var  logic        intrusion_detect_pin_oe,    // Clear pulse active
  output var  logic        int_n_o,                    // Interrupt drive value, low
  output var  logic        int_n_oe,                   // Interrupt asserted
  input  wire logic        test_select_analog_out,     // Test select pin level
  output var  logic        analog_out_en,              // Analog output allowed
  input  wire logic        reset_n_pin_i,              // Reset pin level
  output var  logic        reset_n_pin_o,              // Drive value, low
  output var  logic        reset_n_pin_oe,             // Reset pulse active
  output var  logic [1:0]  strap_addr                  // Captured address bits
);
  import monitor_pin_pkg::*;

  localparam logic [6:0] SYNC_INIT = 7'h23; // Idle bus lines and reset pin high

  if (PULSE_CYCLES < 2) $error("PULSE_CYCLES must be at least two");

  // Pin samples: [0] sda [1] scl [2] a0 [3] a1 [4] intrusion [5] reset [6] test
  logic [6:0] pin_s;
  logic       sda_s, scl_s, a0_s, a1_s, ci_s, rstpin_s, test_s;

  bit_sync #(.W(7), .INIT(SYNC_INIT)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({test_select_analog_out, reset_n_pin_i, intrusion_detect_pin_i,
            addr_bit1_strap, addr_bit0_test_out_i, scl_i, sda_i}), // RQ9
    .q    (pin_s)
  );
  assign {test_s, rstpin_s, ci_s, a1_s, a0_s, scl_s, sda_s} = pin_s;

  pulse_if ci_pi ();
  pulse_if rst_pi ();

  pulse_timer #(.CYCLES(PULSE_CYCLES)) u_ci_timer (
    .clk  (clk),
    .nrst (nrst),
    .pi   (ci_pi.timer)
  );
  pulse_timer #(.CYCLES(PULSE_CYCLES)) u_rst_timer (
    .clk  (clk),
    .nrst (nrst),
    .pi   (rst_pi.timer)
  );

  // Register decode, shared by the read and write paths
  function automatic reg_sel_t decode(input logic [11:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'b00) begin
      case (a[9:2])
        `IDX_CFG:      s = SEL_CFG;
        `IDX_RST_CTL:  s = SEL_RST_CTL;
        `IDX_CI_CLR:   s = SEL_CI_CLR;
        `IDX_IRQ_STAT: s = SEL_STAT;
        `IDX_IRQ_MASK: s = SEL_MASK;
        `IDX_PIN_STAT: s = SEL_PIN;
        default:       s = SEL_NONE;
      endcase
    end
    if (a[11:10] != 2'b00) begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  logic [7:0]  cfg_r, cfg_nxt;
  logic [7:0]  rst_ctl_r, rst_ctl_nxt;
  logic [7:0]  ci_clr_r, ci_clr_nxt;
  logic [3:0]  stat_r, stat_nxt;
  logic [3:0]  mask_r, mask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        int_oe_r, int_oe_nxt;
  logic        a0_oe_r, a0_oe_nxt;
  logic        a0_o_r, a0_o_nxt;
  logic        aout_en_r, aout_en_nxt;
  logic [1:0]  strap_r, strap_nxt;
  logic [2:0]  guard_r, guard_nxt;
  logic        scl_d_r, sda_d_r;
  logic        ci_start_r, ci_start_nxt;
  logic        rst_start_r, rst_start_nxt;

  logic        setup, wr_acc, ext_rst, ci_req, rst_req;
  logic [3:0]  events;
  logic [5:0]  pin_stat;
  reg_sel_t    rd_sel, wr_sel;

  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pready_r && pwrite && !pslverr_r;
  assign rd_sel   = decode(paddr);
  assign wr_sel   = decode(paddr);
  assign pin_stat = {rst_pi.busy, ci_pi.busy, test_s, ci_s, strap_r};
  // Own reset pulse reads back through the synchroniser, so it is masked
  assign ext_rst  = !rstpin_s && !rst_pi.busy && (guard_r == 3'h0); // RQ8
  assign ci_req   = cfg_r[`CFG_CI_GO] || ci_clr_r[`CICLR_GO]; // RQ4
  assign rst_req  = cfg_r[`CFG_RST_GO] && rst_ctl_r[`RSTCTL_EN]; // RQ7

  // Sticky events; a start is data falling while the serial clock stays high
  always_comb begin
    events = 4'h0;
    events[`EV_INTRUSION] = ci_s; // RQ3
    events[`EV_CI_DONE]   = ci_pi.done;
    events[`EV_RST_DONE]  = rst_pi.done;
    events[`EV_BUS_START] = scl_s && scl_d_r && sda_d_r && !sda_s;
  end

  assign ci_pi.start   = ci_start_r;
  assign ci_pi.abort   = ext_rst;
  assign rst_pi.start  = rst_start_r;
  assign rst_pi.abort  = 1'b0;

  // Next values of the register file, bus answer and pin controls
  always_comb begin
    cfg_nxt       = cfg_r;
    rst_ctl_nxt   = rst_ctl_r;
    ci_clr_nxt    = ci_clr_r;
    mask_nxt      = mask_r;
    stat_nxt      = stat_r;
    prdata_nxt    = prdata_r;
    pslverr_nxt   = pslverr_r;
    pready_nxt    = 1'b0;
    // Answer is prepared in setup so that access completes in one cycle
    if (setup) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = (rd_sel == SEL_NONE);
      case (rd_sel)
        SEL_CFG:     prdata_nxt = {24'h0, cfg_r};
        SEL_RST_CTL: prdata_nxt = {24'h0, rst_ctl_r};
        SEL_CI_CLR:  prdata_nxt = {24'h0, ci_clr_r};
        SEL_STAT:    prdata_nxt = {28'h0, stat_r};
        SEL_MASK:    prdata_nxt = {28'h0, mask_r};
        SEL_PIN:     prdata_nxt = {26'h0, pin_stat};
        default:     prdata_nxt = 32'h0;
      endcase
    end
    // Pulse request bits are set by software and cleared only on expiry or by an external reset
    if (wr_acc) begin
      case (wr_sel)
        SEL_CFG: begin
          cfg_nxt = pwdata[7:0];
          cfg_nxt[`CFG_CI_GO]  = cfg_r[`CFG_CI_GO] || pwdata[`CFG_CI_GO]; // RQ4
          cfg_nxt[`CFG_RST_GO] = cfg_r[`CFG_RST_GO] ||
                                 (pwdata[`CFG_RST_GO] && rst_ctl_r[`RSTCTL_EN]); // RQ7
        end
        SEL_RST_CTL: rst_ctl_nxt = pwdata[7:0];
        SEL_CI_CLR:  ci_clr_nxt[`CICLR_GO] = ci_clr_r[`CICLR_GO] || pwdata[`CICLR_GO]; // RQ4
        SEL_STAT:    stat_nxt = stat_r & ~pwdata[3:0];
        SEL_MASK:    mask_nxt = pwdata[3:0];
        default:     stat_nxt = stat_r;
      endcase
    end
    if (ci_pi.done) begin
      cfg_nxt[`CFG_CI_GO]   = 1'b0; // RQ12
      ci_clr_nxt[`CICLR_GO] = 1'b0; // RQ12
    end
    if (rst_pi.done) begin
      cfg_nxt[`CFG_RST_GO] = 1'b0; // RQ12
    end
    // A new event wins over a clear in the same cycle
    stat_nxt      = stat_nxt | events;
    ci_start_nxt  = ci_req && !ci_pi.busy && !ci_start_r && !ci_pi.done;
    rst_start_nxt = rst_req && !rst_pi.busy && !rst_start_r && !rst_pi.done;
    guard_nxt     = {guard_r[1:0], rst_pi.busy};
    // Reset pin pulled low from outside restores all defaults
    if (ext_rst) begin
      cfg_nxt       = `RST_CFG; // RQ10
      rst_ctl_nxt   = `RST_RST_CTL; // RQ10
      ci_clr_nxt    = `RST_CI_CLR; // RQ10
      stat_nxt      = `RST_IRQ_STAT; // RQ10
      mask_nxt      = `RST_IRQ_MASK; // RQ10
      ci_start_nxt  = 1'b0;
      rst_start_nxt = 1'b0;
    end
    int_oe_nxt  = cfg_r[`CFG_INT_EN] && ((stat_r & mask_r) != 4'h0) && !ext_rst; // RQ5
    a0_oe_nxt   = test_s; // RQ2 RQ6
    a0_o_nxt    = !(a1_s && ci_s && scl_s && sda_s && rstpin_s); // RQ2
    aout_en_nxt = !test_s; // RQ6
    strap_nxt   = test_s ? strap_r : {a1_s, a0_s}; // RQ1
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r       <= `RST_CFG;
      rst_ctl_r   <= `RST_RST_CTL;
      ci_clr_r    <= `RST_CI_CLR;
      stat_r      <= `RST_IRQ_STAT;
      mask_r      <= `RST_IRQ_MASK;
      prdata_r    <= 32'h0;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
      int_oe_r    <= 1'b0;
      a0_oe_r     <= 1'b0;
      a0_o_r      <= 1'b0;
      aout_en_r   <= 1'b0;
      strap_r     <= 2'h0;
      guard_r     <= 3'h0;
      scl_d_r     <= 1'b1;
      sda_d_r     <= 1'b1;
      ci_start_r  <= 1'b0;
      rst_start_r <= 1'b0;
    end else begin
      cfg_r       <= cfg_nxt;
      rst_ctl_r   <= rst_ctl_nxt;
      ci_clr_r    <= ci_clr_nxt;
      stat_r      <= stat_nxt;
      mask_r      <= mask_nxt;
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      int_oe_r    <= int_oe_nxt;
      a0_oe_r     <= a0_oe_nxt;
      a0_o_r      <= a0_o_nxt;
      aout_en_r   <= aout_en_nxt;
      strap_r     <= strap_nxt;
      guard_r     <= guard_nxt;
      scl_d_r     <= scl_s;
      sda_d_r     <= sda_s;
      ci_start_r  <= ci_start_nxt;
      rst_start_r <= rst_start_nxt;
    end
  end

  // Open-drain pins only ever drive low
  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign addr_bit0_test_out_o    = a0_o_r;
  assign addr_bit0_test_out_oe   = a0_oe_r;
  assign sda_o                   = 1'b0; // RQ9
  assign sda_oe                  = 1'b0; // RQ9
  assign intrusion_detect_pin_o  = 1'b0;
  assign intrusion_detect_pin_oe = ci_pi.busy; // RQ4
  assign int_n_o                 = 1'b0;
  assign int_n_oe                = int_oe_r; // RQ5
  assign analog_out_en           = aout_en_r;
  assign reset_n_pin_o           = 1'b0;
  assign reset_n_pin_oe          = rst_pi.busy; // RQ7
  assign strap_addr              = strap_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence ci_cmd_s;
    wr_acc && wr_sel == SEL_CFG && pwdata[`CFG_CI_GO] && !ci_pi.busy && !ext_rst
      && !ci_pi.done;
  endsequence
  // Request bit, then start flop, then timer drive: pin low from the third edge
  sequence ci_drive_s;
    ##3 intrusion_detect_pin_oe;
  endsequence

  int_gate_a: assert property (!cfg_r[`CFG_INT_EN] |=> !int_n_oe) // RQ5
    else $error("interrupt driven while disabled");
  ci_pulse_start_a: assert property (ci_cmd_s |-> ci_drive_s) // RQ4
    else $error("intrusion clear pulse did not start");
  rst_enable_gate_a: assert property (rst_start_r |-> $past(rst_ctl_r[`RSTCTL_EN])) // RQ7
    else $error("reset pulse without enable");
  go_bit_clear_a: assert property (ci_pi.done && !ext_rst
                                   |=> !cfg_r[`CFG_CI_GO] && !ci_clr_r[`CICLR_GO]) // RQ12
    else $error("request bit not cleared at expiry");
  ext_reset_a: assert property (ext_rst |=> cfg_r == `RST_CFG && mask_r == `RST_IRQ_MASK
                                && !int_n_oe) // RQ8 RQ10
    else $error("external reset did not restore defaults");
  intrusion_seen_a: assert property (ci_s && !ext_rst |=> stat_r[`EV_INTRUSION]) // RQ3
    else $error("intrusion level not recorded");
  nand_output_a: assert property (test_s |=> addr_bit0_test_out_oe && !analog_out_en) // RQ2 RQ6
    else $error("test mode did not take strap pin");
  strap_track_a: assert property (!test_s |=> strap_addr == $past({a1_s, a0_s})) // RQ1
    else $error("strap address not tracked");
  apb_answer_a: assert property (setup |=> pready ##1 !pready)
    else $error("bus answer not one cycle");
endmodule
`default_nettype wire

/* smbus_host_model.sv */
// Serial bus host model: one start, two clocks and a stop per request
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
  input  wire logic go,      // Rising edge starts one frame
  output var  logic scl,     // Serial clock, idle high
  output var  logic sda_low  // Pulls serial data low
);
  // Clock stands high between frames, as a released bus with pull-ups
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    forever begin
      @(posedge go);
      #62.5 sda_low = 1'b1;
      #62.5 scl = 1'b0;
      repeat (2) begin
        #62.5 scl = 1'b1;
        #62.5 scl = 1'b0;
      end
      #62.5 scl = 1'b1;
      #62.5 sda_low = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* monitor_digital_pin_control_tb_top.sv */
// Self-checking bench of the monitor pin control block
`timescale 1ns/100ps
`default_nettype none
`include "monitor_pin_cfg.svh"
module monitor_digital_pin_control_tb_top;
  localparam int unsigned PW = 16;
  localparam logic [11:0] A_CFG = {2'b00, `IDX_CFG, 2'b00};
  localparam logic [11:0] A_RST = {2'b00, `IDX_RST_CTL, 2'b00};
  localparam logic [11:0] A_CI = {2'b00, `IDX_CI_CLR, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, `IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {2'b00, `IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_PIN = {2'b00, `IDX_PIN_STAT, 2'b00};
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        a0_drv, a1_drv, a0_o, a0_oe, sda_o, sda_oe, scl, sda_low, go;
  logic        ci_latch, ci_o, ci_oe, int_o, int_oe, test_sel, an_en;
  logic        reset_ext, rp_o, rp_oe;
  logic [1:0]  strap;
  int          mismatches, total_checks, ci_len, rp_len, sda_drv, b;
  // Pin levels resolved from every party's drive; pull-ups on bus and reset
  wire logic a0_pin = a0_oe ? a0_o : a0_drv;
  wire logic ci_pin = ci_oe ? ci_o : ci_latch;
  wire logic rst_pin = rp_oe ? rp_o : reset_ext;
  wire logic sda_pin = (sda_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

  monitor_pin_ctrl #(.PULSE_CYCLES(PW)) monitor_pin_ctrl_i (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_bit0_test_out_i(a0_pin), .addr_bit0_test_out_o(a0_o),
    .addr_bit0_test_out_oe(a0_oe), .addr_bit1_strap(a1_drv), .sda_i(sda_pin),
    .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl), .intrusion_detect_pin_i(ci_pin),
    .intrusion_detect_pin_o(ci_o), .intrusion_detect_pin_oe(ci_oe), .int_n_o(int_o),
    .int_n_oe(int_oe), .test_select_analog_out(test_sel), .analog_out_en(an_en),
    .reset_n_pin_i(rst_pin), .reset_n_pin_o(rp_o), .reset_n_pin_oe(rp_oe),
    .strap_addr(strap));
  smbus_host_model smbus_host_model_i (.go(go), .scl(scl), .sda_low(sda_low));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // External latch drops while pulled low; pulse widths kept as running sums
  always @(posedge clk) begin
    if (ci_oe && !ci_o) ci_latch <= 1'b0;
    ci_len <= ci_len + int'(ci_oe && !ci_o);
    rp_len <= rp_len + int'(rp_oe && !rp_o);
    sda_drv <= sda_drv + int'(sda_oe);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    bit ok;
    ok = 1'b0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    r = 32'h0;
    e = 1'b1;
    // Answer taken at the rising edge that sees pready high
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = (pready === 1'b1);
      if (ok) begin
        r = prdata;
        e = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, 32'h0);
  endtask

  task automatic t_reset_vals;
    logic [11:0] regs [5] = '{A_CFG, A_RST, A_CI, A_STAT, A_MASK};
    logic [31:0] r;
    logic        e;
    foreach (regs[i]) rd_chk(regs[i], 32'h0);
    check({31'h0, int_oe}, 32'h0);
    apb(1'b0, 12'h004, 32'h0, r, e);
    check({r[30:0], e}, 32'h1);
    $display("test reset_vals done");
  endtask
  task automatic t_strap;
    a0_drv <= 1'b1;
    cyc(6);
    check({30'h0, strap}, 32'h1);
    rd_chk(A_PIN, 32'h1);
    a0_drv <= 1'b0;
    a1_drv <= 1'b1;
    cyc(6);
    check({30'h0, strap}, 32'h2);
    $display("test strap done");
  endtask
  // Both ways of asking for the latch clear pulse
  task automatic t_ci_clear;
    logic [11:0] adr [2] = '{A_CFG, A_CI};
    logic [31:0] dat [2] = '{32'h40, 32'h80};
    foreach (adr[i]) begin
      ci_latch <= 1'b1;
      cyc(6);
      b = ci_len;
      wr(adr[i], dat[i]);
      cyc(PW + 8);
      check(ci_len - b, PW);
      check({31'h0, ci_latch}, 32'h0);
      rd_chk(adr[i], 32'h0);
      rd_chk(A_STAT, 32'h3);
      wr(A_STAT, 32'hf);
      rd_chk(A_STAT, 32'h0);
    end
    $display("test ci_clear done");
  endtask
  task automatic t_reset_pulse;
    b = rp_len;
    wr(A_CFG, 32'h10);
    cyc(PW + 8);
    check(rp_len - b, 0);
    wr(A_RST, 32'h80);
    b = rp_len;
    wr(A_CFG, 32'h10);
    cyc(PW + 8);
    check(rp_len - b, PW);
    rd_chk(A_CFG, 32'h0);
    rd_chk(A_STAT, 32'h4);
    wr(A_STAT, 32'hf);
    $display("test reset_pulse done");
  endtask
  task automatic t_irq;
    ci_latch <= 1'b1;
    cyc(6);
    rd_chk(A_STAT, 32'h1);
    wr(A_CFG, 32'h2);
    cyc(3);
    check({31'h0, int_oe}, 32'h0);
    wr(A_MASK, 32'h1);
    cyc(3);
    check({int_o, int_oe}, 32'h1);
    wr(A_CFG, 32'h0);
    cyc(3);
    check({31'h0, int_oe}, 32'h0);
    wr(A_CFG, 32'h2);
    ci_latch <= 1'b0;
    cyc(6);
    wr(A_STAT, 32'h1);
    cyc(3);
    check({31'h0, int_oe}, 32'h0);
    $display("test irq done");
  endtask
  // All tree inputs high gives a low result; one low input flips it
  task automatic t_test_mode;
    ci_latch <= 1'b1;
    test_sel <= 1'b1;
    cyc(6);
    check({a0_oe, a0_o, an_en}, 32'h4);
    ci_latch <= 1'b0;
    cyc(6);
    check({31'h0, a0_o}, 32'h1);
    test_sel <= 1'b0;
    cyc(6);
    check({a0_oe, an_en}, 32'h1);
    wr(A_STAT, 32'hf);
    $display("test test_mode done");
  endtask
  task automatic t_bus_start;
    go <= 1'b1;
    cyc(200);
    go <= 1'b0;
    rd_chk(A_STAT, 32'h8);
    check(sda_drv, 0);
    $display("test bus_start done");
  endtask
  task automatic t_ext_reset;
    wr(A_MASK, 32'hf);
    wr(A_RST, 32'h80);
    reset_ext <= 1'b0;
    cyc(10);
    reset_ext <= 1'b1;
    cyc(10);
    rd_chk(A_MASK, 32'h0);
    rd_chk(A_RST, 32'h0);
    rd_chk(A_CFG, 32'h0);
    check({31'h0, int_oe}, 32'h0);
    $display("test ext_reset done");
  endtask

  // Hang guard well beyond the longest sequence
  initial begin
    #300000;
    mismatches++;
    end_of_test();
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {a0_drv, a1_drv, ci_latch, test_sel, go} = '0;
    reset_ext = 1'b1;
    {mismatches, total_checks, ci_len, rp_len, sda_drv} = '0;
    cyc(20);
    nrst <= 1'b1;
    cyc(2);
    t_reset_vals();
    t_strap();
    t_ci_clear();
    t_reset_pulse();
    t_irq();
    t_test_mode();
    t_bus_start();
    t_ext_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
